// File: mdc_ctrl.sv
/*
 * Upper front-end control bits, filter interrupt routing and the
 * clock-correction measurement of decoder sync bits over a 32 kHz window.
 * Assumes all inputs are synchronous to mclk_i except ref32k_i, and that
 * decoder sync indications are one-cycle pulses.
 */
// Our own choice: strobed register access.
module mdc_ctrl (
	input  wire logic        mclk_i,            // System clock, 10 MHz
	input  wire logic        sys_rst_i,         // Synchronous reset, active high
	input  wire logic [7:0]  reg_addr_i,        // Register address
	input  wire logic [15:0] reg_wdata_i,       // Write data
	input  wire logic        reg_wr_i,          // Write strobe
	input  wire logic        reg_rd_i,          // Read strobe
	input  wire logic        reg_core_i,        // Accessing core, 1 = processing
	output logic      [15:0] reg_rdata_o,       // Read data, cycle after read
	input  wire logic        processing_core_active_i, // Chooses select copy
	input  wire logic        pin_output_mode_bit_p03_i, // Mode bit, port 0 bit 3
	input  wire logic        pin_output_mode_bit_p20_i, // Mode bit, port 2 bit 0
	input  wire logic        ref32k_i,          // 32 kHz reference, asynchronous
	input  wire logic [2:0]  sync_bit_i,        // Sync bit pulses, decoders 0..2
	input  wire logic [5:0]  filt_flag_i,       // Filter output buffer flags
	input  wire logic [5:0]  filt_clr_req_i,    // Flag clear requests
	input  wire logic        filt_clr_core_i,   // Core issuing the clear
	output logic             decoder1_enable_o, // Decoder 1 and filters enable
	output logic             decoder2_enable_o, // Decoder 2 and filters enable
	output logic             dec1_in_diff_o,    // Decoder 1 positive input differential
	output logic             dec2_in_diff_o,    // Decoder 2 positive input differential
	output logic             sample_clock_speed_sel_o, // Sampling speed select
	output logic [2:0]       buf_irq_enable_o,  // Pair enables 54, 32, 10
	output logic             irq_core_select_o, // Interrupt owner, 1 = processing
	output logic             irq_sup_o,         // Filter interrupt to supervisory core
	output logic             irq_proc_o,        // Filter interrupt to processing core
	output logic [5:0]       filt_clr_o,        // Accepted flag clears
	output logic             meas_busy_o        // Measurement in progress
);

	// ==========================================================
	// Decode
	// ==========================================================
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_a);
		hit = (a == reg_a);
	endfunction : hit

	logic [15:0]      ctrl_q;
	logic [15:0]      ctrl_d;
	logic [1:0]       sel_sup_q;
	logic [1:0]       sel_proc_q;
	logic [15:0]      ccc_q;
	logic [15:0]      cnt_q;
	logic [9:0]       edges_q;
	logic [2:0]       ref_sync_q;
	logic [1:0]       meas_src_q;
	mdc_pkg::mdc_state_t state_q;
	mdc_pkg::mdc_state_t state_d;

	wire              wr_ctrl    = reg_wr_i && hit(reg_addr_i, mdc_pkg::ADDR_CTRL);
	wire              wr_sel     = reg_wr_i && hit(reg_addr_i, mdc_pkg::ADDR_SEL);
	wire [1:0]        wsel       = reg_wdata_i[mdc_pkg::SEL_LSB +: 2];
	// Only the copy owned by the active core drives the measurement
	wire              sel_active = wr_sel && (reg_core_i == processing_core_active_i);
	wire              meas_start = sel_active && (wsel != mdc_pkg::SEL_DISABLE);
	wire              meas_stop  = sel_active && (wsel == mdc_pkg::SEL_DISABLE);
	wire [15:0]       wr_mask    = (reg_core_i == mdc_pkg::CORE_SUP) ?
	                               (mdc_pkg::CTRL_SUP_MASK | mdc_pkg::CTRL_ANY_MASK) :
	                               mdc_pkg::CTRL_ANY_MASK;
	wire              ref_rise   = ref_sync_q[1] && !ref_sync_q[2];
	wire              win_done   = ref_rise && (edges_q == mdc_pkg::WIN_EDGES - 10'h001);
	wire              sync_hit   = (meas_src_q != mdc_pkg::SEL_DISABLE) &&
	                               sync_bit_i[meas_src_q];
	wire [5:0]        pair_en    = {{2{ctrl_q[mdc_pkg::BIT_IRQ54_EN]}},
	                                {2{ctrl_q[mdc_pkg::BIT_IRQ32_EN]}},
	                                {2{ctrl_q[mdc_pkg::BIT_IRQ10_EN]}}};
	wire              irq_any    = |(filt_flag_i & pair_en);
	wire              core_sel   = ctrl_q[mdc_pkg::BIT_CORE_SEL];
	wire [1:0]        sel_own    = (reg_core_i == mdc_pkg::CORE_PROC) ? sel_proc_q : sel_sup_q;
	wire [15:0]       rd_mux     = hit(reg_addr_i, mdc_pkg::ADDR_CTRL) ?
	                                 {ctrl_q[15:mdc_pkg::CTRL_LSB], 9'h000} :
	                               hit(reg_addr_i, mdc_pkg::ADDR_CCC) ? ccc_q :
	                               hit(reg_addr_i, mdc_pkg::ADDR_SEL) ?
	                                 {10'h000, sel_own, 4'h0} : 16'h0000;

	assign ctrl_d = wr_ctrl ? ((ctrl_q & ~wr_mask) | (reg_wdata_i & wr_mask)) : ctrl_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			mdc_pkg::MDC_IDLE:
			begin
				if (meas_start)
					state_d = mdc_pkg::MDC_MEAS;
			end
			mdc_pkg::MDC_MEAS:
			begin
				if (meas_stop || win_done)
					state_d = mdc_pkg::MDC_IDLE;
			end
			default:
				state_d = mdc_pkg::MDC_IDLE;
		endcase
	end

	// ==========================================================
	// Register port
	// ==========================================================
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_q      <= mdc_pkg::CTRL_RST;
			sel_sup_q   <= mdc_pkg::SEL_RST;
			sel_proc_q  <= mdc_pkg::SEL_RST;
			reg_rdata_o <= 16'h0000;
		end
		else
		begin
			ctrl_q      <= ctrl_d;
			reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
			// Inactive copy still stores the value, it just steers nothing
			if (wr_sel && reg_core_i == mdc_pkg::CORE_SUP)
				sel_sup_q <= wsel;
			if (wr_sel && reg_core_i == mdc_pkg::CORE_PROC)
				sel_proc_q <= wsel;
		end
	end

	// ==========================================================
	// Decoder enables and forced input mode
	// ==========================================================
	logic [1:0] diff_q;
	wire  [1:0] dec_en_d  = {ctrl_d[mdc_pkg::BIT_DEC2_EN], ctrl_d[mdc_pkg::BIT_DEC1_EN]};
	wire  [1:0] mode_pin  = {pin_output_mode_bit_p20_i, pin_output_mode_bit_p03_i};

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_dec
			always_ff @(posedge mclk_i)
			begin
				if (sys_rst_i)
					diff_q[g] <= 1'b0;
				else
					diff_q[g] <= dec_en_d[g] && mode_pin[g];
			end
		end
	endgenerate

	assign decoder1_enable_o        = ctrl_q[mdc_pkg::BIT_DEC1_EN];
	assign decoder2_enable_o        = ctrl_q[mdc_pkg::BIT_DEC2_EN];
	assign sample_clock_speed_sel_o = ctrl_q[mdc_pkg::BIT_SPEED];
	assign buf_irq_enable_o         = ctrl_q[mdc_pkg::BIT_IRQ54_EN:mdc_pkg::BIT_IRQ10_EN];
	assign irq_core_select_o        = core_sel;
	assign dec1_in_diff_o           = diff_q[0];
	assign dec2_in_diff_o           = diff_q[1];

	// ==========================================================
	// Interrupt routing and clear ownership
	// ==========================================================
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			irq_sup_o  <= 1'b0;
			irq_proc_o <= 1'b0;
			filt_clr_o <= 6'h00;
		end
		else
		begin
			irq_sup_o  <= irq_any && (core_sel == mdc_pkg::CORE_SUP);
			irq_proc_o <= irq_any && (core_sel == mdc_pkg::CORE_PROC);
			// Clears from the core that does not own the flags are dropped
			filt_clr_o <= (filt_clr_core_i == core_sel) ? filt_clr_req_i : 6'h00;
		end
	end

	// ==========================================================
	// Clock-correction measurement
	// ==========================================================
	// Reference is free running and unrelated to mclk_i, so it is synchronised
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			ref_sync_q <= 3'h0;
		else
			ref_sync_q <= {ref_sync_q[1:0], ref32k_i};
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			state_q    <= mdc_pkg::MDC_IDLE;
			ccc_q      <= mdc_pkg::CCC_RST;
			cnt_q      <= 16'h0000;
			edges_q    <= 10'h000;
			meas_src_q <= mdc_pkg::SEL_DISABLE;
		end
		else
		begin
			state_q <= state_d;
			if (meas_start)
			begin
				// A restart from the active copy reopens the window from zero
				ccc_q      <= mdc_pkg::CCC_RST;
				cnt_q      <= 16'h0000;
				edges_q    <= 10'h000;
				meas_src_q <= wsel;
			end
			else if (state_q == mdc_pkg::MDC_MEAS)
			begin
				if (meas_stop)
					meas_src_q <= mdc_pkg::SEL_DISABLE;
				else if (win_done)
					ccc_q <= cnt_q + {15'h0000, sync_hit};
				else
				begin
					cnt_q <= cnt_q + {15'h0000, sync_hit};
					if (ref_rise)
						edges_q <= edges_q + 10'h001;
				end
			end
		end
	end

	assign meas_busy_o = (state_q == mdc_pkg::MDC_MEAS);

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_sup_ctrl_wr;
		wr_ctrl && reg_core_i == mdc_pkg::CORE_SUP;
	endsequence

	sequence s_window;
		meas_busy_o && win_done && !sel_active;
	endsequence

	property p_dec1_en;
		s_sup_ctrl_wr |=> decoder1_enable_o == $past(reg_wdata_i[mdc_pkg::BIT_DEC1_EN]);
	endproperty
	a_dec1_en: assert property (p_dec1_en) else $error("decoder 1 enable not written");

	property p_dec2_en;
		s_sup_ctrl_wr |=> decoder2_enable_o == $past(reg_wdata_i[mdc_pkg::BIT_DEC2_EN]);
	endproperty
	a_dec2_en: assert property (p_dec2_en) else $error("decoder 2 enable not written");

	property p_disabled_single;
		(!decoder1_enable_o |-> !dec1_in_diff_o) and (!decoder2_enable_o |-> !dec2_in_diff_o);
	endproperty
	a_disabled_single: assert property (p_disabled_single) else $error("mode forced while off");

	property p_mode_pin;
		##1 (dec1_in_diff_o == (decoder1_enable_o && $past(pin_output_mode_bit_p03_i))) &&
		    (dec2_in_diff_o == (decoder2_enable_o && $past(pin_output_mode_bit_p20_i)));
	endproperty
	a_mode_pin: assert property (p_mode_pin) else $error("input mode mismatch");

	property p_proc_locked;
		wr_ctrl && reg_core_i == mdc_pkg::CORE_PROC |=>
			$stable(decoder1_enable_o) && $stable(decoder2_enable_o) &&
			$stable(irq_core_select_o) &&
			sample_clock_speed_sel_o == $past(reg_wdata_i[mdc_pkg::BIT_SPEED]);
	endproperty
	a_proc_locked: assert property (p_proc_locked) else $error("protected bit changed");

	property p_irq_route;
		(irq_any && !core_sel |=> irq_sup_o && !irq_proc_o) and
		(irq_any && core_sel |=> irq_proc_o && !irq_sup_o) and
		(!irq_any |=> !irq_sup_o && !irq_proc_o);
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("interrupt routed wrongly");

	property p_start;
		meas_start |=> meas_busy_o && ccc_q == 16'h0000;
	endproperty
	a_start: assert property (p_start) else $error("write did not start measuring");

	property p_busy_zero;
		meas_busy_o |-> ccc_q == 16'h0000;
	endproperty
	a_busy_zero: assert property (p_busy_zero) else $error("count visible while busy");

	property p_finish;
		s_window |=> !meas_busy_o && ccc_q == $past(cnt_q) + $past({15'h0000, sync_hit});
	endproperty
	a_finish: assert property (p_finish) else $error("final count not loaded");

	property p_reset_zero;
		$past(sys_rst_i) |-> ccc_q == 16'h0000 && !meas_busy_o;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("count not cleared by reset");

	property p_inactive_copy;
		wr_sel && !sel_active && !meas_busy_o |=> !meas_busy_o;
	endproperty
	a_inactive_copy: assert property (p_inactive_copy) else $error("unused copy started");

endmodule : mdc_ctrl

// File: mdc_mod_model.sv
/*
 * Far-side model: delta-sigma modulator sync pulses and the free-running
 * reference, 824 ns period. Assumes the bench requests sync bursts by a one-cycle pulse.
 */
module mdc_mod_model (
	input  wire logic       mclk_i,      // System clock
	input  wire logic       burst_i,     // Start a burst of sync pulses
	input  wire logic [1:0] burst_dec_i, // Decoder that carries the burst
	input  wire logic [3:0] burst_len_i, // Number of sync pulses
	output logic            ref32k_o,    // Reference, free running
	output logic [2:0]      sync_bit_o   // One-cycle sync pulses
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] left_q;
	logic [1:0] dec_q;
	logic       ph_q;
	logic       ref_q;

	// ==========================================================
	// Reference
	// ==========================================================
	// Half period chosen so no edge meets a rising system clock edge
	initial ref_q = 1'b0;
	always #412 ref_q = ~ref_q;
	assign ref32k_o = ref_q;

	// ==========================================================
	// Sync pulses, one every other cycle so each is a separate pulse
	// ==========================================================
	initial begin
		left_q = 4'h0;
		dec_q  = 2'h0;
		ph_q   = 1'b0;
	end
	always @(posedge mclk_i)
	begin
		ph_q <= ~ph_q;
		if (burst_i)
		begin
			left_q <= burst_len_i;
			dec_q  <= burst_dec_i;
		end
		else if (left_q != 4'h0 && ph_q)
			left_q <= left_q - 4'h1;
	end
	assign sync_bit_o = (left_q != 4'h0 && ph_q) ? (3'h1 << dec_q) : 3'h0;

endmodule : mdc_mod_model

// File: mdc_pkg.sv
/*
 * Constants for the decoder front-end control and clock-correction block.
 * Assumes a 16-bit register port with byte-wide addresses and one system clock.
 */
package mdc_pkg;

	// ==========================================================
	// Register addresses
	// ==========================================================
	localparam logic [7:0]  ADDR_CTRL       = 8'h11;
	localparam logic [7:0]  ADDR_CCC        = 8'h12;
	localparam logic [7:0]  ADDR_SEL        = 8'h13;

	// ==========================================================
	// Control register fields
	// ==========================================================
	localparam int          BIT_DEC1_EN     = 9;
	localparam int          BIT_DEC2_EN     = 10;
	localparam int          BIT_SPEED       = 11;
	localparam int          BIT_IRQ10_EN    = 12;
	localparam int          BIT_IRQ32_EN    = 13;
	localparam int          BIT_IRQ54_EN    = 14;
	localparam int          BIT_CORE_SEL    = 15;
	localparam int          CTRL_LSB        = 9;
	// Fields only the supervisory core may write
	localparam logic [15:0] CTRL_SUP_MASK   = 16'h8600;
	// Fields either core may write
	localparam logic [15:0] CTRL_ANY_MASK   = 16'h7800;
	localparam logic [15:0] CTRL_RST        = 16'h0000;

	// ==========================================================
	// Measurement select register and count
	// ==========================================================
	localparam int          SEL_LSB         = 4;
	localparam logic [1:0]  SEL_DISABLE     = 2'h3;
	localparam logic [1:0]  SEL_RST         = 2'h3;
	localparam logic [15:0] CCC_RST         = 16'h0000;
	localparam logic [9:0]  WIN_EDGES       = 10'h200;

	// ==========================================================
	// Core identities and states
	// ==========================================================
	localparam logic        CORE_SUP        = 1'b0;
	localparam logic        CORE_PROC       = 1'b1;

	typedef enum logic [1:0] {
		MDC_IDLE = 2'b01,
		MDC_MEAS = 2'b10
	} mdc_state_t;

endpackage : mdc_pkg

// File: tb_top.sv
/*
 * Self-checking bench for mdc_ctrl: control bits, interrupt routing and the
 * clock-correction measurement. Assumes mdc_mod_model drives reference and sync.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, core = 1'b0, act = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata, got;
	logic        p03 = 1'b0, p20 = 1'b0, clr_core = 1'b0, burst = 1'b0;
	logic [5:0]  flag = 6'h00, clr_req = 6'h00, clr;
	logic [1:0]  bdec = 2'h0;
	logic [3:0]  blen = 4'h0;
	logic [2:0]  sync, birq;
	logic        ref32k, en1, en2, df1, df2, spd, csel, isup, iproc, busy;
	int          n_errors = 0, cmp_count = 0;

	always #50 mclk = ~mclk;

	mdc_ctrl i_dut (.mclk_i(mclk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_core_i(core), .reg_rdata_o(rdata),
		.processing_core_active_i(act), .pin_output_mode_bit_p03_i(p03),
		.pin_output_mode_bit_p20_i(p20), .ref32k_i(ref32k), .sync_bit_i(sync),
		.filt_flag_i(flag), .filt_clr_req_i(clr_req), .filt_clr_core_i(clr_core),
		.decoder1_enable_o(en1), .decoder2_enable_o(en2), .dec1_in_diff_o(df1),
		.dec2_in_diff_o(df2), .sample_clock_speed_sel_o(spd), .buf_irq_enable_o(birq),
		.irq_core_select_o(csel), .irq_sup_o(isup), .irq_proc_o(iproc),
		.filt_clr_o(clr), .meas_busy_o(busy));

	mdc_mod_model i_mod (.mclk_i(mclk), .burst_i(burst), .burst_dec_i(bdec),
		.burst_len_i(blen), .ref32k_o(ref32k), .sync_bit_o(sync));

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic end_of_test;
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic c);
		@(posedge mclk);
		wr <= 1'b1; addr <= a; wdata <= d; core <= c;
		@(posedge mclk);
		wr <= 1'b0;
		@(negedge mclk);
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic c, output logic [15:0] d);
		@(posedge mclk);
		rd <= 1'b1; addr <= a; core <= c;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask : rd_reg

	task automatic clr_try(input logic c, input logic [5:0] exp);
		@(posedge mclk);
		clr_req <= 6'h3f; clr_core <= c;
		@(posedge mclk);
		clr_req <= 6'h00;
		@(negedge mclk);
		chk("flag clear", clr, exp);
	endtask : clr_try

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_reset;
		rd_reg(8'h12, 1'b1, got); chk("count reset", got, 16'h0000);
		rd_reg(8'h11, 1'b0, got); chk("ctrl reset", got, 16'h0000);
		rd_reg(8'h13, 1'b0, got); chk("select reset", got, 16'h0030);
		rd_reg(8'h20, 1'b0, got); chk("unmapped", got, 16'h0000);
	endtask : t_reset

	task automatic t_ctrl;
		@(posedge mclk);
		p03 <= 1'b1;
		p20 <= 1'b0;
		wr_reg(8'h11, 16'hffff, 1'b0);
		repeat (2) @(negedge mclk);
		rd_reg(8'h11, 1'b0, got); chk("ctrl all", got, 16'hfe00);
		chk("dec1 en", en1, 1'b1);
		chk("dec2 en", en2, 1'b1);
		chk("dec1 diff", df1, 1'b1);
		chk("dec2 diff", df2, 1'b0);
		chk("speed", spd, 1'b1);
		chk("pair irq en", birq, 3'h7);
		wr_reg(8'h11, 16'h0000, 1'b1);
		rd_reg(8'h11, 1'b0, got); chk("proc clear", got, 16'h8600);
		chk("speed low", spd, 1'b0);
		wr_reg(8'h11, 16'h0000, 1'b0);
		@(posedge mclk);
		p20 <= 1'b1;
		repeat (2) @(negedge mclk);
		chk("dec1 off", en1, 1'b0);
		chk("dec1 diff off", df1, 1'b0);
		chk("dec2 diff off", df2, 1'b0);
		wr_reg(8'h11, 16'hffff, 1'b1);
		rd_reg(8'h11, 1'b1, got); chk("proc set", got, 16'h7800);
	endtask : t_ctrl

	task automatic t_irq;
		wr_reg(8'h11, 16'h1000, 1'b0);
		@(posedge mclk);
		flag <= 6'h01;
		repeat (2) @(negedge mclk);
		chk("irq sup", isup, 1'b1);
		chk("irq proc", iproc, 1'b0);
		@(posedge mclk);
		flag <= 6'h04;
		repeat (2) @(negedge mclk);
		chk("irq masked", isup, 1'b0);
		clr_try(1'b1, 6'h00);
		clr_try(1'b0, 6'h3f);
		wr_reg(8'h11, 16'hf000, 1'b0);
		@(posedge mclk);
		flag <= 6'h20;
		repeat (2) @(negedge mclk);
		chk("owner bit", csel, 1'b1);
		chk("irq proc on", iproc, 1'b1);
		chk("irq sup off", isup, 1'b0);
		clr_try(1'b0, 6'h00);
		clr_try(1'b1, 6'h3f);
		@(posedge mclk);
		flag <= 6'h00;
	endtask : t_irq

	// Starts from core c, bursts n pulses on decoder sel early in the window
	task automatic meas(input logic c, input logic [1:0] sel, input logic [3:0] n);
		int k;
		wr_reg(8'h13, {10'h0, sel, 4'h0}, c);
		chk("busy start", busy, 1'b1);
		rd_reg(8'h12, ~c, got); chk("count busy", got, 16'h0000);
		repeat (50) @(posedge mclk);
		burst <= 1'b1; bdec <= sel; blen <= n;
		@(posedge mclk);
		burst <= 1'b0; bdec <= sel ^ 2'h3; blen <= 4'h0;
		k = 0;
		while (busy !== 1'b0 && k < 6000)
		begin
			@(negedge mclk);
			k++;
		end
		if (busy !== 1'b0)
		begin
			n_errors++;
			$display("BAD measurement never ended");
			end_of_test();
		end
		rd_reg(8'h12, c, got); chk("count", got, {12'h0, n});
	endtask : meas

	task automatic t_meas;
		meas(1'b0, 2'h1, 4'h5);
		wr_reg(8'h13, 16'h0010, 1'b0);
		wr_reg(8'h13, 16'h0030, 1'b0);
		chk("abort busy", busy, 1'b0);
		rd_reg(8'h12, 1'b0, got); chk("abort count", got, 16'h0000);
		wr_reg(8'h13, 16'h0020, 1'b1);
		chk("idle copy", busy, 1'b0);
		rd_reg(8'h13, 1'b1, got); chk("proc copy", got, 16'h0020);
		rd_reg(8'h13, 1'b0, got); chk("sup copy", got, 16'h0030);
		@(posedge mclk);
		act <= 1'b1;
		meas(1'b1, 2'h2, 4'h4);
		meas(1'b1, 2'h0, 4'h3);
	endtask : t_meas

	// Reset in mid-run with a nonzero count and written registers
	task automatic t_mid_reset;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(8'h12, 1'b0, got); chk("count mid reset", got, 16'h0000);
		rd_reg(8'h11, 1'b0, got); chk("ctrl mid reset", got, 16'h0000);
		rd_reg(8'h13, 1'b1, got); chk("proc copy reset", got, 16'h0030);
		chk("busy mid reset", busy, 1'b0);
	endtask : t_mid_reset

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_ctrl();
		t_irq();
		t_meas();
		t_mid_reset();
		end_of_test();
	end

endmodule : tb_top
